// >>> common/ldcb_params.svh
// constants of the logical device configuration bank
// How it works
// - primary base from indices 0x60/0x61
// - second base 0x62/0x63 used by no device, reads zero
// - unused base registers ignore writes, read zero
// - base registers reset to 0x00 always
// - primary irq select 0x70 in each non-reserved bank
// - irq select resets 0x06 device 0 else 0x00
// - 0x72 only for keyboard, else reads zero
// - interrupts default to active-high edge
// - reserved indices ignore writes, read zero
// - dma select 0x74 only floppy and parallel
// - dma reset 0x02 device 0, 0x04 devices 3,5
// - device on when activate or power bit set
// - activate and power bits follow each other
// - out-of-range base disables the device decode
// - floppy, serial: eight bytes, 8-aligned range
// - parallel 4-aligned; epp only when 8-aligned
// - keyboard fixed at addresses 60 and 64
// - game port one byte, 0x0100 to 0x0FFF
// - reachable only in configuration state, index/data
// - decode bits 11:0, upper bits if qualified
`ifndef LDCB_PARAMS_SVH
`define LDCB_PARAMS_SVH
`define LDCB_NUM_LD 10
`define LDCB_LD_FLOPPY 4'h0
`define LDCB_LD_PAR 4'h3
`define LDCB_LD_SER1 4'h4
`define LDCB_LD_SER2 4'h5
`define LDCB_LD_KBD 4'h7
`define LDCB_LD_GAME 4'h9
`define LDCB_IDX_ACT 8'h30
`define LDCB_IDX_BASE_HI 8'h60
`define LDCB_IDX_BASE_LO 8'h61
`define LDCB_IDX_BASE2_HI 8'h62
`define LDCB_IDX_BASE2_LO 8'h63
`define LDCB_IDX_IRQ1 8'h70
`define LDCB_IDX_IRQ2 8'h72
`define LDCB_IDX_DMA 8'h74
`define LDCB_CFG_DATA_OFS 16'h0001
`define LDCB_RST_ZERO 8'h00
`define LDCB_IRQ1_RST_FLOPPY 8'h06
`define LDCB_DMA_RST_FLOPPY 8'h02
`define LDCB_DMA_RST_PAR_SER2 8'h04
`define LDCB_BASE_USED_MASK 10'h239
`define LDCB_BASE2_USED_MASK 10'h000
`define LDCB_DMA_USED_MASK 10'h009
`define LDCB_LD_USED_MASK 10'h2B9
`define LDCB_BASE_MIN 16'h0100
`define LDCB_MAX_8ALIGN 16'h0FF8
`define LDCB_MAX_PAR 16'h0FFC
`define LDCB_MAX_GAME 16'h0FFF
`define LDCB_KBD_DATA 12'h060
`define LDCB_KBD_CMD 12'h064
`define LDCB_EPP_FIRST 3'h3
`endif

// >>> common/ldcb_pkg.sv
// types shared by the logical device configuration bank
package ldcb_pkg;
   typedef enum logic [3:0] {
      LDCB_REG_NONE,
      LDCB_REG_ACT,
      LDCB_REG_BASE_HI,
      LDCB_REG_BASE_LO,
      LDCB_REG_BASE2_HI,
      LDCB_REG_BASE2_LO,
      LDCB_REG_IRQ1,
      LDCB_REG_IRQ2,
      LDCB_REG_DMA
   } ldcb_reg_t;
endpackage

// >>> src/ldcb_regmap.sv
// index and device number to implemented register kind
`timescale 1ns/1ps
`default_nettype none
`include "ldcb_params.svh"
module ldcb_regmap (
   input wire logic [7:0] index,
   input wire logic [7:0] ldn,
   output ldcb_pkg::ldcb_reg_t kind
);
   // true when bit ldn of a per-device mask is set
   function automatic logic uses(input logic [9:0] mask, input logic [7:0] n);
      uses = (n < 8'h0A) && mask[n[3:0]];
   endfunction

   // reserved devices and unused registers map to none
   wire logic ld_ok = uses(`LDCB_LD_USED_MASK, ldn);
   wire logic base_ok = uses(`LDCB_BASE_USED_MASK, ldn);
   wire logic base2_ok = uses(`LDCB_BASE2_USED_MASK, ldn);
   wire logic dma_ok = uses(`LDCB_DMA_USED_MASK, ldn);
   wire logic kbd = (ldn == {4'h0, `LDCB_LD_KBD});

   // everything not listed here is reserved and reads zero
   assign kind = !ld_ok ? ldcb_pkg::LDCB_REG_NONE :
      (index == `LDCB_IDX_ACT) ? ldcb_pkg::LDCB_REG_ACT :
      (index == `LDCB_IDX_BASE_HI && base_ok) ? ldcb_pkg::LDCB_REG_BASE_HI :
      (index == `LDCB_IDX_BASE_LO && base_ok) ? ldcb_pkg::LDCB_REG_BASE_LO :
      (index == `LDCB_IDX_BASE2_HI && base2_ok) ? ldcb_pkg::LDCB_REG_BASE2_HI :
      (index == `LDCB_IDX_BASE2_LO && base2_ok) ? ldcb_pkg::LDCB_REG_BASE2_LO :
      (index == `LDCB_IDX_IRQ1) ? ldcb_pkg::LDCB_REG_IRQ1 :
      (index == `LDCB_IDX_IRQ2 && kbd) ? ldcb_pkg::LDCB_REG_IRQ2 :
      (index == `LDCB_IDX_DMA && dma_ok) ? ldcb_pkg::LDCB_REG_DMA :
      ldcb_pkg::LDCB_REG_NONE;
endmodule
`default_nettype wire

// >>> src/ldcb_range.sv
// base range check and i/o address decode for one logical device
`timescale 1ns/1ps
`default_nettype none
`include "ldcb_params.svh"
module ldcb_range #(
   parameter logic [3:0] DEV = 4'h0
) (
   input wire logic [15:0] base,
   input wire logic [15:0] io_addr,
   input wire logic qual16,
   output logic in_range,
   output logic hit,
   output logic epp_hit
);
   // upper address bits only count under 16-bit qualification
   wire logic hi_ok = !qual16 || (io_addr[15:12] == 4'h0);
   wire logic above_min = (base >= `LDCB_BASE_MIN);
   wire logic [11:0] a = io_addr[11:0];

   generate
      if (DEV == `LDCB_LD_FLOPPY || DEV == `LDCB_LD_SER1 || DEV == `LDCB_LD_SER2) begin : g8
         // eight registers on an 8-byte boundary
         assign in_range = above_min && base <= `LDCB_MAX_8ALIGN && base[2:0] == 3'h0;
         assign hit = in_range && hi_ok && a[11:3] == base[11:3];
         assign epp_hit = 1'b0;
      end else if (DEV == `LDCB_LD_PAR) begin : gpar
         // epp window at +3..+7 needs an 8-byte boundary
         wire logic std = a[11:2] == base[11:2] && a[1:0] != 2'h3;
         assign in_range = above_min && base <= `LDCB_MAX_PAR && base[1:0] == 2'h0;
         assign epp_hit = in_range && hi_ok && base[2] == 1'b0 &&
            a[11:3] == base[11:3] && a[2:0] >= `LDCB_EPP_FIRST;
         assign hit = (in_range && hi_ok && std) || epp_hit;
      end else if (DEV == `LDCB_LD_KBD) begin : gkbd
         // not relocatable: the base registers play no part
         assign in_range = 1'b1;
         assign hit = hi_ok && (a == `LDCB_KBD_DATA || a == `LDCB_KBD_CMD);
         assign epp_hit = 1'b0;
      end else if (DEV == `LDCB_LD_GAME) begin : ggame
         // a single byte anywhere in range
         assign in_range = above_min && base <= `LDCB_MAX_GAME;
         assign hit = in_range && hi_ok && a == base[11:0];
         assign epp_hit = 1'b0;
      end else begin : gnone
         // reserved number: never decodes
         assign in_range = 1'b0;
         assign hit = 1'b0;
         assign epp_hit = 1'b0;
      end
   endgenerate
endmodule
`default_nettype wire

// >>> src/ldcb_top.sv
// logical device configuration bank: index/data access, storage and decode
`timescale 1ns/1ps
`default_nettype none
`include "ldcb_params.svh"
module ldcb_top (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic soft_rst,
   input wire logic cfg_state,
   input wire logic [15:0] cfg_base,
   input wire logic [7:0] ldn_sel,
   input wire logic qual16_en,
   input wire logic [15:0] io_addr,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_wdata,
   input wire logic pwr_wr,
   input wire logic [3:0] pwr_dev,
   input wire logic pwr_val,
   output logic [7:0] io_rdata_q,
   output logic io_rvalid_q,
   output logic [9:0] dev_on_q,
   output logic [9:0] dev_sel_q,
   output logic epp_sel_q,
   output logic [39:0] irq_sel_q,
   output logic [3:0] kbd_irq2_sel_q,
   output logic [5:0] dma_sel_q,
   output logic [15:0] floppy_base_q,
   output logic irq_edge_high_q
);
   // reset value of the primary interrupt select per device
   function automatic logic [7:0] irq1_rst(input int unsigned d);
      irq1_rst = (d == 0) ? `LDCB_IRQ1_RST_FLOPPY : `LDCB_RST_ZERO;
   endfunction

   // reset value of the dma channel select per device
   function automatic logic [7:0] dma_rst(input int unsigned d);
      if (d == 0) begin
         dma_rst = `LDCB_DMA_RST_FLOPPY;
      end else if (d == 3 || d == 5) begin
         dma_rst = `LDCB_DMA_RST_PAR_SER2;
      end else begin
         dma_rst = `LDCB_RST_ZERO;
      end
   endfunction

   // config port hits only count in the configuration state
   wire logic [15:0] cfg_data_addr = 16'(cfg_base + `LDCB_CFG_DATA_OFS);
   wire logic idx_hit = cfg_state && (io_addr == cfg_base);
   wire logic dat_hit = cfg_state && (io_addr == cfg_data_addr);
   wire logic cfg_any = idx_hit || dat_hit;
   wire logic data_wr = io_wr && dat_hit;
   wire logic data_rd = io_rd && dat_hit;

   // both reset sources load the same defaults, except irq_edge_high_q, which only nrst clears
   wire logic clr = !nrst || soft_rst;

   // index register written through the index port
   logic [7:0] index_q;
   logic [7:0] index_d;

   assign index_d = (io_wr && idx_hit) ? io_wdata : index_q;

   always_ff @(posedge sys_clk) begin
      if (clr) begin
         index_q <= 8'h00;
      end else begin
         index_q <= index_d;
      end
   end

   // the bank shown is the one the global device number picks
   ldcb_pkg::ldcb_reg_t kind;

   ldcb_regmap u_regmap (
      .index(index_q),
      .ldn(ldn_sel),
      .kind(kind)
   );

   // per-device contents gathered for the read mux
   logic [7:0] bh_w [`LDCB_NUM_LD];
   logic [7:0] bl_w [`LDCB_NUM_LD];
   logic [7:0] b2h_w [`LDCB_NUM_LD];
   logic [7:0] b2l_w [`LDCB_NUM_LD];
   logic [7:0] irq1_w [`LDCB_NUM_LD];
   logic [7:0] irq2_w [`LDCB_NUM_LD];
   logic [7:0] dma_w [`LDCB_NUM_LD];
   logic [9:0] act_w;
   logic [9:0] pwr_w;
   logic [9:0] hit_w;
   logic [9:0] rng_w;
   logic par_epp_w;

   genvar d;
   generate
      for (d = 0; d < `LDCB_NUM_LD; d = d + 1) begin : g_ld
         logic [7:0] bh_q;
         logic [7:0] bl_q;
         logic [7:0] b2h_q;
         logic [7:0] b2l_q;
         logic [7:0] irq1_q;
         logic [7:0] irq2_q;
         logic [7:0] dma_q;
         logic act_q;
         logic pwr_q;
         logic epp_w;

         // this bank is written through the data port only while it is the selected one
         wire logic sel = (ldn_sel == 8'(d));
         wire logic we = data_wr && sel;
         wire logic pw = pwr_wr && (pwr_dev == 4'(d));

         // register writes; kind is none for anything unused
         always_ff @(posedge sys_clk) begin
            if (clr) begin
               bh_q <= `LDCB_RST_ZERO;
               bl_q <= `LDCB_RST_ZERO;
               b2h_q <= `LDCB_RST_ZERO;
               b2l_q <= `LDCB_RST_ZERO;
               irq1_q <= irq1_rst(d);
               irq2_q <= `LDCB_RST_ZERO;
               dma_q <= dma_rst(d);
            end else if (we) begin
               case (kind)
                  ldcb_pkg::LDCB_REG_BASE_HI: bh_q <= io_wdata;
                  ldcb_pkg::LDCB_REG_BASE_LO: bl_q <= io_wdata;
                  ldcb_pkg::LDCB_REG_BASE2_HI: b2h_q <= io_wdata;
                  ldcb_pkg::LDCB_REG_BASE2_LO: b2l_q <= io_wdata;
                  ldcb_pkg::LDCB_REG_IRQ1: irq1_q <= io_wdata;
                  ldcb_pkg::LDCB_REG_IRQ2: irq2_q <= io_wdata;
                  ldcb_pkg::LDCB_REG_DMA: dma_q <= io_wdata;
                  default: ;
               endcase
            end
         end

         // activate and power bits move together; the power port wins a tie
         wire logic act_wr = we && (kind == ldcb_pkg::LDCB_REG_ACT);
         wire logic link_d = pw ? pwr_val : (act_wr ? io_wdata[0] : act_q);

         always_ff @(posedge sys_clk) begin
            if (clr) begin
               act_q <= 1'b0;
               pwr_q <= 1'b0;
            end else begin
               act_q <= link_d;
               pwr_q <= link_d;
            end
         end

         // range and address decode for this device
         ldcb_range #(
            .DEV(4'(d))
         ) u_range (
            .base({bh_q, bl_q}),
            .io_addr(io_addr),
            .qual16(qual16_en),
            .in_range(rng_w[d]),
            .hit(hit_w[d]),
            .epp_hit(epp_w)
         );

         if (d == 3) begin : g_epp
            assign par_epp_w = epp_w;
         end

         assign bh_w[d] = bh_q;
         assign bl_w[d] = bl_q;
         assign b2h_w[d] = b2h_q;
         assign b2l_w[d] = b2l_q;
         assign irq1_w[d] = irq1_q;
         assign irq2_w[d] = irq2_q;
         assign dma_w[d] = dma_q;
         assign act_w[d] = act_q;
         assign pwr_w[d] = pwr_q;
      end
   endgenerate

   // read mux; unused and reserved locations give zero
   wire logic [3:0] ldn4 = ldn_sel[3:0];
   wire logic [3:0] ldi = (ldn4 < 4'hA) ? ldn4 : 4'h0;
   logic [7:0] rd_val;

   assign rd_val =
      (kind == ldcb_pkg::LDCB_REG_ACT) ? {7'h00, act_w[ldi]} :
      (kind == ldcb_pkg::LDCB_REG_BASE_HI) ? bh_w[ldi] :
      (kind == ldcb_pkg::LDCB_REG_BASE_LO) ? bl_w[ldi] :
      (kind == ldcb_pkg::LDCB_REG_BASE2_HI) ? b2h_w[ldi] :
      (kind == ldcb_pkg::LDCB_REG_BASE2_LO) ? b2l_w[ldi] :
      (kind == ldcb_pkg::LDCB_REG_IRQ1) ? irq1_w[ldi] :
      (kind == ldcb_pkg::LDCB_REG_IRQ2) ? irq2_w[ldi] :
      (kind == ldcb_pkg::LDCB_REG_DMA) ? dma_w[ldi] :
      8'h00;

   // read answers one cycle after the strobe
   always_ff @(posedge sys_clk) begin
      if (clr) begin
         io_rdata_q <= 8'h00;
         io_rvalid_q <= 1'b0;
      end else begin
         io_rdata_q <= data_rd ? rd_val : 8'h00;
         io_rvalid_q <= data_rd;
      end
   end

   // a device is on when either linked bit is set
   wire logic [9:0] on_w = act_w | pwr_w;

   // device selects: strobe, device on, base in range, not a config access
   wire logic strobe = (io_rd || io_wr) && !cfg_any;
   wire logic [9:0] sel_w = strobe ? (hit_w & on_w & rng_w) : 10'h000;
   wire logic epp_w_all = strobe && par_epp_w && on_w[3] && rng_w[3];

   always_ff @(posedge sys_clk) begin
      if (clr) begin
         dev_on_q <= 10'h000;
         dev_sel_q <= 10'h000;
         epp_sel_q <= 1'b0;
      end else begin
         dev_on_q <= on_w;
         dev_sel_q <= sel_w;
         epp_sel_q <= epp_w_all;
      end
   end

   // routing outputs: low nibble of each irq select, three dma bits
   logic [39:0] irq_d;
   genvar k;
   generate
      for (k = 0; k < `LDCB_NUM_LD; k = k + 1) begin : g_irq
         assign irq_d[4*k +: 4] = irq1_w[k][3:0];
      end
   endgenerate

   always_ff @(posedge sys_clk) begin
      if (clr) begin
         irq_sel_q <= 40'h0000000000;
         kbd_irq2_sel_q <= 4'h0;
         dma_sel_q <= 6'h00;
         floppy_base_q <= 16'h0000;
      end else begin
         irq_sel_q <= irq_d;
         kbd_irq2_sel_q <= irq2_w[7][3:0];
         dma_sel_q <= {dma_w[3][2:0], dma_w[0][2:0]};
         floppy_base_q <= {bh_w[0], bl_w[0]};
      end
   end

   // fixed polarity: active-high edge, no control to change it here
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         irq_edge_high_q <= 1'b0;
      end else begin
         irq_edge_high_q <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// >>> test/ldcb_checker.sv
// port-level assertions for the logical device configuration bank
`timescale 1ns/1ps
`default_nettype none
module ldcb_checker (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic soft_rst,
   input wire logic cfg_state,
   input wire logic [15:0] cfg_base,
   input wire logic qual16_en,
   input wire logic [15:0] io_addr,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_rdata_q,
   input wire logic io_rvalid_q,
   input wire logic [9:0] dev_sel_q,
   input wire logic epp_sel_q,
   input wire logic [15:0] floppy_base_q,
   input wire logic irq_edge_high_q
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst || soft_rst);
   // a data-port read while the configuration state is open
   wire logic data_rd = cfg_state && io_rd && io_addr == cfg_base + 16'h0001;
   chk_read_answer: assert property (data_rd |=> io_rvalid_q)
      else $error("data port read got no answer");
   chk_idle_rdata: assert property (!io_rvalid_q |-> io_rdata_q == 8'h00)
      else $error("read data not zero outside answer");
   chk_sel_cause: assert property (dev_sel_q != 10'h000 |-> $past(io_rd || io_wr))
      else $error("device select without a strobe");
   chk_epp_window: assert property (epp_sel_q |-> $past(io_addr[2:0]) >= 3'h3)
      else $error("epp select below offset 3");
   chk_kbd_fixed: assert property (dev_sel_q[7] |->
      $past(io_addr[11:0]) inside {12'h060, 12'h064})
      else $error("keyboard select off its fixed ports");
   chk_floppy_span: assert property (dev_sel_q[0] |->
      $past(io_addr[11:3]) == floppy_base_q[11:3])
      else $error("floppy select outside its eight bytes");
   chk_qual_upper: assert property (qual16_en && io_addr[15:12] != 4'h0 &&
      (io_rd || io_wr) |=> dev_sel_q == 10'h000)
      else $error("select with upper address bits set");
   chk_edge_high: assert property ($past(nrst) && $past(nrst, 2) |-> irq_edge_high_q)
      else $error("interrupts not active-high edge");
endmodule
bind ldcb_top ldcb_checker chk_i (.sys_clk(sys_clk), .nrst(nrst), .soft_rst(soft_rst),
   .cfg_state(cfg_state), .cfg_base(cfg_base), .qual16_en(qual16_en), .io_addr(io_addr),
   .io_wr(io_wr), .io_rd(io_rd), .io_rdata_q(io_rdata_q), .io_rvalid_q(io_rvalid_q),
   .dev_sel_q(dev_sel_q), .epp_sel_q(epp_sel_q), .floppy_base_q(floppy_base_q),
   .irq_edge_high_q(irq_edge_high_q));
`default_nettype wire

// >>> test/ldcb_host_model.sv
// host model driving the index, data and device i/o strobes
`timescale 1ns/1ps
`default_nettype none
module ldcb_host_model (
   input wire logic sys_clk,
   output logic [15:0] io_addr,
   output logic io_wr,
   output logic io_rd,
   output logic [7:0] io_wdata
);
   // bus idle and released at time zero
   initial begin
      io_addr = 16'hFFFF;
      io_wr = 1'b0;
      io_rd = 1'b0;
      io_wdata = 8'hFF;
   end
   // an idle edge first, so back-to-back calls never reassign a line in one time step;
   // one strobe held across exactly one edge; released address and data show the inverse,
   // so a late sample of stale data cannot pass by luck
   task automatic xfer(input logic [15:0] a, input logic w, input logic [7:0] d);
      @(posedge sys_clk);
      #10;
      io_addr = a;
      io_wr = w;
      io_rd = !w;
      io_wdata = d;
      @(posedge sys_clk);
      #10;
      io_wr = 1'b0;
      io_rd = 1'b0;
      io_wdata = ~d;
      io_addr = ~a;
   endtask
endmodule
`default_nettype wire

// >>> test/tb_top.sv
// self-checking testbench of the logical device configuration bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic sys_clk, nrst, soft_rst, cfg_state, qual16_en, pwr_wr, pwr_val;
   logic io_wr, io_rd, io_rvalid_q, epp_sel_q, irq_edge_high_q;
   logic [15:0] cfg_base, io_addr, floppy_base_q;
   logic [7:0] ldn_sel, io_wdata, io_rdata_q;
   logic [3:0] pwr_dev, kbd_irq2_sel_q;
   logic [9:0] dev_on_q, dev_sel_q;
   logic [39:0] irq_sel_q;
   logic [5:0] dma_sel_q;
   int fails, samples_checked, cycles;
   ldcb_host_model host (.sys_clk(sys_clk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
      .io_wdata(io_wdata));
   ldcb_top uut (.sys_clk(sys_clk), .nrst(nrst), .soft_rst(soft_rst), .cfg_state(cfg_state),
      .cfg_base(cfg_base), .ldn_sel(ldn_sel), .qual16_en(qual16_en), .io_addr(io_addr),
      .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .pwr_wr(pwr_wr), .pwr_dev(pwr_dev),
      .pwr_val(pwr_val), .io_rdata_q(io_rdata_q), .io_rvalid_q(io_rvalid_q),
      .dev_on_q(dev_on_q), .dev_sel_q(dev_sel_q), .epp_sel_q(epp_sel_q),
      .irq_sel_q(irq_sel_q), .kbd_irq2_sel_q(kbd_irq2_sel_q), .dma_sel_q(dma_sel_q),
      .floppy_base_q(floppy_base_q), .irq_edge_high_q(irq_edge_high_q));
   task automatic end_sim;
      if (fails == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // bank chosen first, then index, then data
   task automatic set(input logic [7:0] ld, input logic [7:0] idx, input logic [7:0] val);
      ldn_sel = ld;
      host.xfer(cfg_base, 1'b1, idx);
      host.xfer(cfg_base + 16'h0001, 1'b1, val);
   endtask
   task automatic get(input logic [7:0] ld, input logic [7:0] idx, input logic [7:0] exp);
      ldn_sel = ld;
      host.xfer(cfg_base, 1'b1, idx);
      host.xfer(cfg_base + 16'h0001, 1'b0, 8'h00);
      chk({7'h00, io_rvalid_q, io_rdata_q}, {8'h01, exp});
   endtask
   // device access; select pulse is looked at in the cycle it stands
   task automatic sel(input logic [15:0] a, input logic [15:0] exp);
      host.xfer(a, 1'b0, 8'h00);
      chk({5'h00, epp_sel_q, dev_sel_q}, exp);
   endtask
   task automatic t_reset;
      for (int d = 0; d < 10; d++) begin
         get(8'(d), 8'h60, 8'h00);
         get(8'(d), 8'h70, (d == 0) ? 8'h06 : 8'h00);
         get(8'(d), 8'h74, (d == 0) ? 8'h02 : (d == 3) ? 8'h04 : 8'h00);
      end
      chk({12'h000, irq_sel_q[3:0]}, 16'h0006);
      chk({10'h000, dma_sel_q}, 16'h0022);
      chk({15'h0000, irq_edge_high_q}, 16'h0001);
   endtask
   task automatic t_regs;
      logic [7:0] idx [6] = '{8'h62, 8'h71, 8'h73, 8'h75, 8'hA8, 8'hDF};
      set(8'h00, 8'h60, 8'h03);
      set(8'h00, 8'h61, 8'hF0);
      get(8'h00, 8'h60, 8'h03);
      chk(floppy_base_q, 16'h03F0);
      foreach (idx[i]) begin
         set(8'h00, idx[i], 8'h5A);
         get(8'h00, idx[i], 8'h00);
      end
      set(8'h00, 8'h72, 8'h0C);
      get(8'h00, 8'h72, 8'h00);
      set(8'h07, 8'h72, 8'h0C);
      // routing outputs are registered once more behind the stored value
      @(posedge sys_clk);
      #10;
      chk({12'h000, kbd_irq2_sel_q}, 16'h000C);
      set(8'h07, 8'h60, 8'h03);
      get(8'h07, 8'h60, 8'h00);
      set(8'h04, 8'h74, 8'h01);
      get(8'h04, 8'h74, 8'h00);
      set(8'h06, 8'h70, 8'h05);
      get(8'h06, 8'h70, 8'h00);
      set(8'h04, 8'h70, 8'h04);
      @(posedge sys_clk);
      #10;
      chk({12'h000, irq_sel_q[19:16]}, 16'h0004);
      cfg_state = 1'b0;
      set(8'h04, 8'h70, 8'h09);
      cfg_state = 1'b1;
      get(8'h04, 8'h70, 8'h04);
   endtask
   task automatic t_power;
      set(8'h09, 8'h30, 8'h01);
      @(posedge sys_clk);
      #10;
      chk({6'h00, dev_on_q}, 16'h0200);
      pwr_dev = 4'h9;
      pwr_wr = 1'b1;
      @(posedge sys_clk);
      #10;
      pwr_wr = 1'b0;
      get(8'h09, 8'h30, 8'h00);
      chk({6'h00, dev_on_q}, 16'h0000);
   endtask
   task automatic t_decode;
      set(8'h00, 8'h30, 8'h01);
      sel(16'h03F5, 16'h0001);
      sel(16'h03F8, 16'h0000);
      set(8'h00, 8'h60, 8'h00);
      sel(16'h00F0, 16'h0000);
      set(8'h03, 8'h60, 8'h03);
      set(8'h03, 8'h61, 8'h78);
      set(8'h03, 8'h30, 8'h01);
      host.xfer(16'h037B, 1'b0, 8'h00);
      chk({15'h0000, epp_sel_q}, 16'h0001);
      set(8'h03, 8'h61, 8'h7C);
      sel(16'h037F, 16'h0000);
      sel(16'h037C, 16'h0008);
      set(8'h07, 8'h30, 8'h01);
      sel(16'h0060, 16'h0080);
      sel(16'h0064, 16'h0080);
      sel(16'h0061, 16'h0000);
      set(8'h09, 8'h60, 8'h02);
      set(8'h09, 8'h61, 8'h01);
      set(8'h09, 8'h30, 8'h01);
      sel(16'h0202, 16'h0000);
      sel(16'h1201, 16'h0200);
      qual16_en = 1'b1;
      sel(16'h1201, 16'h0000);
   endtask
   task automatic t_soft;
      soft_rst = 1'b1;
      @(posedge sys_clk);
      #10;
      soft_rst = 1'b0;
      get(8'h00, 8'h70, 8'h06);
      get(8'h09, 8'h61, 8'h00);
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   // a hang counts as a failure
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fails++;
         end_sim;
      end
   end
   initial begin
      {nrst, soft_rst, qual16_en, pwr_wr, pwr_val, pwr_dev, ldn_sel} = '0;
      {fails, samples_checked, cycles} = '0;
      cfg_state = 1'b1;
      cfg_base = 16'h002E;
      repeat (5) @(posedge sys_clk);
      #10;
      nrst = 1'b1;
      t_reset;
      t_regs;
      t_power;
      t_decode;
      t_soft;
      end_sim;
   end
endmodule
`default_nettype wire
